// file: warmup_consts.svh
/*
  constants of the cascaded warm-up counter: register offsets, field
  positions, reset values and clock figures.
  assumes inclusion by bare name from the package and the design module.
*/
`ifndef WARMUP_CONSTS_SVH
`define WARMUP_CONSTS_SVH

// register byte offsets
`define OFS_LOWER_CTL     8'h00
`define OFS_UPPER_CTL     8'h04
`define OFS_LOWER_CMP     8'h08
`define OFS_UPPER_CMP     8'h0C
`define OFS_SYSCTL2       8'h10
`define OFS_STATUS        8'h14

// timer control fields
`define CTL_RUN_BIT       3
`define CTL_CK_HI         6
`define CTL_CK_LO         4
`define CTL_MODE_HI       2
`define CTL_MODE_LO       0
`define CK_SEL_SLOW       3'h4
`define CK_SEL_FAST       3'h6
`define MODE_CASCADE      3'h3
`define MODE_WARMUP       3'h5

// system control two fields
`define SYS_FAST_EN_BIT   7
`define SYS_SLOW_EN_BIT   6
`define SYS_SLOW_SEL_BIT  5

// status fields
`define STAT_RUN_BIT      16
`define STAT_DONE_BIT     17

// reset values
`define RST_CTL           8'h00
`define RST_CMP           8'hFF
`define RST_SYSCTL2       8'h80

// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// source clock figures: slow clock in Hz, ticks per compare step
`define SLOW_CLK_HZ       32768
`define TICKS_PER_STEP    256

`endif

// file: warmup_pkg.sv
/*
  types of the cascaded warm-up counter: axi4-lite carriers.
  assumes warmup_consts.svh on the include path.
*/
package warmup_pkg;
  `include "warmup_consts.svh"

  // master to slave
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  // slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;
endpackage : warmup_pkg

// file: cascaded_warmup_counter.sv
/*
  cascaded 16-bit warm-up counter with its control registers, reached
  over axi4-lite.
  assumes both oscillator clocks arrive as asynchronous pins and are far
  slower than clk_sys; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "warmup_consts.svh"
module cascaded_warmup_counter
  import warmup_pkg::*;
(
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst,
  // register bus
  input  wire axi_req_t axiReq,
  output axi_rsp_t      axiRsp,
  // oscillator clock pins
  input  wire logic     slowClock,
  input  wire logic     fastClock,
  // oscillator and clock-select controls
  output logic          fastOscEnable,
  output logic          slowOscEnable,
  output logic          slowClockSelect,
  // warm-up done request, one-cycle pulse
  output logic          warmupDoneIrq
);

  logic [7:0]  lowerCtlQ;
  logic [7:0]  upperCtlQ;
  logic [7:0]  lowerCmpQ;
  logic [7:0]  upperCmpQ;
  logic [7:0]  sysCtlQ;
  logic [15:0] countQ;
  logic        doneQ;
  logic        irqQ;

  // oscillator pin synchronisers, one per source
  logic [1:0]  pinIn;
  logic [1:0]  riseTick;

  assign pinIn = {fastClock, slowClock};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      // local per source, so no register has two writing processes
      logic [2:0] stageQ;
      logic       levelQ;
      // stage 0 feeds only stage 1; edges judged on stages 1 and 2
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stageQ <= 3'h0;
          levelQ <= 1'b0;
        end else begin
          stageQ <= {stageQ[1:0], pinIn[gi]};
          if (stageQ[1] == stageQ[2]) begin
            levelQ <= stageQ[2];
          end
        end
      end
      assign riseTick[gi] = (stageQ[1] == stageQ[2]) &&
                            stageQ[2] && !levelQ;
    end
  endgenerate

  // mode decode and source selection
  logic [2:0] lowerCk;
  logic       runBit;
  logic       warmMode;
  logic       srcTick;
  logic       countTick;
  logic [15:0] nextCount;
  logic       matchHit;

  assign lowerCk  = lowerCtlQ[`CTL_CK_HI:`CTL_CK_LO];
  assign runBit   = upperCtlQ[`CTL_RUN_BIT];
  assign warmMode = (upperCtlQ[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_WARMUP) &&
                    (lowerCtlQ[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_CASCADE);
  // other source codes belong to modes not built here, so they never count
  always_comb begin
    unique case (lowerCk)
      `CK_SEL_SLOW: srcTick = riseTick[0];
      `CK_SEL_FAST: srcTick = riseTick[1];
      default:      srcTick = 1'b0;
    endcase
  end
  assign countTick = runBit && warmMode && srcTick;
  assign nextCount = countQ + 16'h0001;
  // low compare byte is ignored, so periods are whole 256-tick steps; a high byte of 0 matches on the first tick
  assign matchHit  = countTick && (nextCount[15:8] == upperCmpQ);

  // up-counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      countQ <= 16'h0000;
    end else if (!runBit) begin
      countQ <= 16'h0000;
    end else if (matchHit) begin
      countQ <= 16'h0000;
    end else if (countTick) begin
      countQ <= nextCount;
    end
  end

  // match request and sticky done flag
  logic       wrGo;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic       doneClr;

  assign doneClr = wrGo && wrStrb[2] && (wrAddr == `OFS_STATUS) &&
                   wrData[`STAT_DONE_BIT];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqQ  <= 1'b0;
      doneQ <= 1'b0;
    end else begin
      irqQ <= matchHit;
      // a match in the clearing cycle wins
      if (matchHit) begin
        doneQ <= 1'b1;
      end else if (doneClr) begin
        doneQ <= 1'b0;
      end
    end
  end
  assign warmupDoneIrq = irqQ;

  // write channel: address and data taken in either order
  logic        awHeldQ;
  logic        wHeldQ;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        bValidQ;
  logic [1:0]  bRespQ;
  logic        awFire;
  logic        wFire;
  logic        wrMapped;

  assign axiRsp.awready = !awHeldQ && !bValidQ;
  assign axiRsp.wready  = !wHeldQ && !bValidQ;
  assign awFire = axiReq.awvalid && axiRsp.awready;
  assign wFire  = axiReq.wvalid && axiRsp.wready;
  assign wrGo   = (awHeldQ || awFire) && (wHeldQ || wFire);
  assign wrAddr = awHeldQ ? awAddrQ : axiReq.awaddr;
  assign wrData = wHeldQ ? wDataQ : axiReq.wdata;
  assign wrStrb = wHeldQ ? wStrbQ : axiReq.wstrb;
  assign wrMapped = (wrAddr <= `OFS_STATUS) && (wrAddr[1:0] == 2'h0);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeldQ <= 1'b0;
      wHeldQ  <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
      bValidQ <= 1'b0;
      bRespQ  <= `RESP_OKAY;
    end else begin
      if (wrGo) begin
        awHeldQ <= 1'b0;
        wHeldQ  <= 1'b0;
        bValidQ <= 1'b1;
        bRespQ  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (awFire) begin
          awHeldQ <= 1'b1;
          awAddrQ <= axiReq.awaddr;
        end
        if (wFire) begin
          wHeldQ <= 1'b1;
          wDataQ <= axiReq.wdata;
          wStrbQ <= axiReq.wstrb;
        end
        if (bValidQ && axiReq.bready) begin
          bValidQ <= 1'b0;
        end
      end
    end
  end
  assign axiRsp.bvalid = bValidQ;
  assign axiRsp.bresp  = bRespQ;

  // register writes; a 16-bit compare lands through the lower offset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowerCtlQ <= `RST_CTL;
      upperCtlQ <= `RST_CTL;
      lowerCmpQ <= `RST_CMP;
      upperCmpQ <= `RST_CMP;
      sysCtlQ   <= `RST_SYSCTL2;
    end else if (wrGo) begin
      unique case (wrAddr)
        `OFS_LOWER_CTL: if (wrStrb[0]) lowerCtlQ <= wrData[7:0];
        `OFS_UPPER_CTL: if (wrStrb[0]) upperCtlQ <= wrData[7:0];
        `OFS_LOWER_CMP: begin
          if (wrStrb[0]) lowerCmpQ <= wrData[7:0];
          if (wrStrb[1]) upperCmpQ <= wrData[15:8];
        end
        `OFS_UPPER_CMP: if (wrStrb[0]) upperCmpQ <= wrData[7:0];
        `OFS_SYSCTL2:   if (wrStrb[0]) sysCtlQ <= wrData[7:0];
        default: ; // status and unmapped words store nothing
      endcase
    end
  end

  // oscillator controls straight from system control two
  assign fastOscEnable   = sysCtlQ[`SYS_FAST_EN_BIT];
  assign slowOscEnable   = sysCtlQ[`SYS_SLOW_EN_BIT];
  assign slowClockSelect = sysCtlQ[`SYS_SLOW_SEL_BIT];

  // read channel, answer one cycle after the address is taken
  logic        rValidQ;
  logic [31:0] rDataQ;
  logic [1:0]  rRespQ;
  logic [31:0] rdMux;
  logic        rdOk;

  always_comb begin
    rdMux = 32'h0000_0000;
    rdOk  = 1'b1;
    unique case (axiReq.araddr)
      `OFS_LOWER_CTL: rdMux[7:0] = lowerCtlQ;
      `OFS_UPPER_CTL: rdMux[7:0] = upperCtlQ;
      `OFS_LOWER_CMP: rdMux[15:0] = {upperCmpQ, lowerCmpQ};
      `OFS_UPPER_CMP: rdMux[7:0] = upperCmpQ;
      `OFS_SYSCTL2:   rdMux[7:0] = sysCtlQ;
      `OFS_STATUS: begin
        rdMux[15:0] = countQ;
        rdMux[`STAT_RUN_BIT]  = runBit && warmMode;
        rdMux[`STAT_DONE_BIT] = doneQ;
      end
      default: rdOk = 1'b0;
    endcase
  end

  assign axiRsp.arready = !rValidQ;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rValidQ <= 1'b0;
      rDataQ  <= 32'h0000_0000;
      rRespQ  <= `RESP_OKAY;
    end else if (axiReq.arvalid && !rValidQ) begin
      rValidQ <= 1'b1;
      rDataQ  <= rdMux;
      rRespQ  <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rValidQ && axiReq.rready) begin
      rValidQ <= 1'b0;
    end
  end
  assign axiRsp.rvalid = rValidQ;
  assign axiRsp.rdata  = rDataQ;
  assign axiRsp.rresp  = rRespQ;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sMatch;
    matchHit;
  endsequence

  sequence sSlowStep;
    countTick && !matchHit && (lowerCk == `CK_SEL_SLOW);
  endsequence

  sequence sFastStep;
    countTick && !matchHit && (lowerCk == `CK_SEL_FAST);
  endsequence

  sequence sSysWrite;
    wrGo && wrStrb[0] && (wrAddr == `OFS_SYSCTL2);
  endsequence

  a_match_clears: assert property (
    sMatch |=> (countQ == 16'h0000) && warmupDoneIrq && doneQ)
    else $error("match did not clear counter and raise request");

  a_irq_has_cause: assert property (
    warmupDoneIrq |-> $past(matchHit))
    else $error("request raised without a match");

  a_start_gates: assert property (
    !runBit |=> (countQ == 16'h0000) ##1
      ((countQ == 16'h0000) || $past(runBit)))
    else $error("counter moved while stopped");

  a_stop_zeroes: assert property (
    $fell(runBit) |=> (countQ == 16'h0000) && !warmupDoneIrq ##1
      ((countQ == 16'h0000) || $past(runBit)))
    else $error("stop did not return counter to zero");

  a_slow_step: assert property (
    sSlowStep |=> countQ == $past(countQ) + 16'h0001)
    else $error("slow tick did not advance counter");

  a_fast_step: assert property (
    sFastStep |=> countQ == $past(countQ) + 16'h0001)
    else $error("fast tick did not advance counter");

  a_high_byte_only: assert property (
    sMatch |-> (upperCmpQ == 8'h00) ||
      ((countQ[7:0] == 8'hFF) && (countQ[15:8] == upperCmpQ - 8'h01)))
    else $error("match not decided by high compare byte");

  a_warm_mode_only: assert property (
    (countQ != 16'h0000) |-> $past(warmMode) || $past(countQ) == countQ)
    else $error("counter advanced outside warm-up mode");

  a_sysctl_bits: assert property (
    sSysWrite |=> fastOscEnable == $past(wrData[`SYS_FAST_EN_BIT]) &&
      slowOscEnable == $past(wrData[`SYS_SLOW_EN_BIT]) &&
      slowClockSelect == $past(wrData[`SYS_SLOW_SEL_BIT]))
    else $error("system control two bits not on outputs");

  a_source_select: assert property (
    countTick |-> (lowerCk == `CK_SEL_SLOW) || (lowerCk == `CK_SEL_FAST))
    else $error("counting from an unsupported source");

endmodule : cascaded_warmup_counter

// file: test_cascaded_warmup_counter.sv
/*
  self-checking bench of the cascaded warm-up counter: axi4-lite tasks,
  oscillator pin ticks and slow and fast warm-up sequences.
  assumes warmup_pkg and the design are compiled before this file.
*/
`timescale 1ns/1ps
module test_cascaded_warmup_counter
  import warmup_pkg::*;
;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  axi_req_t    axiReq    = '0;
  axi_rsp_t    axiRsp;
  logic        slowClock = 1'b0;
  logic        fastClock = 1'b0;
  logic        fastOscEnable;
  logic        slowOscEnable;
  logic        slowClockSelect;
  logic        warmupDoneIrq;
  int          failures  = 0;
  int          compares  = 0;
  int          irqCount  = 0;
  logic [31:0] rd;
  logic [1:0]  resp;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  cascaded_warmup_counter dut (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .axiReq         (axiReq),
    .axiRsp         (axiRsp),
    .slowClock      (slowClock),
    .fastClock      (fastClock),
    .fastOscEnable  (fastOscEnable),
    .slowOscEnable  (slowOscEnable),
    .slowClockSelect(slowClockSelect),
    .warmupDoneIrq  (warmupDoneIrq)
  );

  // counts high cycles, so a stuck request shows as extra pulses
  always @(posedge clk_sys) begin
    if (warmupDoneIrq === 1'b1) irqCount <= irqCount + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkResp(input logic [1:0] exp);
    compares++;
    if (resp !== exp) begin
      failures++;
      $display("wrong value at %0t: response %h", $time, resp);
    end
  endtask : chkResp

  // write with both address and data offered together, bready held
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_sys);
    axiReq.awaddr  <= a;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= s;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid === 1'b1) begin
        resp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    axiReq.araddr  <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid === 1'b1) begin
        rd = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
    chk(rd, exp);
  endtask : rdChk

  // system control two write, then the three control pins
  task automatic sys(input logic [7:0] v, input logic [2:0] pins);
    wr(8'h10, {24'h0000_00, v}, 4'h1);
    chk({29'h0, fastOscEnable, slowOscEnable, slowClockSelect},
        {29'h0, pins});
  endtask : sys

  // slow or fast pin: 4 cycles high, 5 low, so each edge clears the synchroniser
  task automatic tick(input logic fast, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      fastClock <= fast;
      slowClock <= !fast;
      repeat (4) @(posedge clk_sys);
      fastClock <= 1'b0;
      slowClock <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : tick

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog: the tests take about 7k cycles
  initial begin
    #1_000_000;
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values and an unmapped read
    rdChk(8'h10, 32'h0000_0080);
    rdChk(8'h0C, 32'h0000_00FF);
    rdChk(8'h18, 32'h0000_0000);
    chkResp(2'h2);
    // unmapped write is refused with an error response
    wr(8'h18, 32'h0000_00FF, 4'h1);
    chkResp(2'h2);
    // slow warm-up; low compare byte FF must not delay the match
    sys(8'hC0, 3'b110);
    chkResp(2'h0);
    wr(8'h00, 32'h0000_0043, 4'h1);
    rdChk(8'h00, 32'h0000_0043);
    wr(8'h04, 32'h0000_0005, 4'h1);
    rdChk(8'h04, 32'h0000_0005);
    rdChk(8'h14, 32'h0000_0000);
    wr(8'h08, 32'h0000_01FF, 4'h3);
    rdChk(8'h0C, 32'h0000_0001);
    wr(8'h04, 32'h0000_000D, 4'h1);
    tick(1'b0, 255);
    rdChk(8'h14, 32'h0001_00FF);
    chk(32'(irqCount), 32'h0);
    tick(1'b0, 1);
    chk(32'(irqCount), 32'h1);
    rdChk(8'h14, 32'h0003_0000);
    // service: stop, select slow, drop fast
    wr(8'h04, 32'h0000_0005, 4'h1);
    sys(8'hE0, 3'b111);
    sys(8'h60, 3'b011);
    rdChk(8'h14, 32'h0002_0000);
    wr(8'h14, 32'h0002_0000, 4'h4);
    rdChk(8'h14, 32'h0000_0000);
    // fast warm-up with a stop in mid-count
    sys(8'hE0, 3'b111);
    wr(8'h00, 32'h0000_0063, 4'h1);
    rdChk(8'h00, 32'h0000_0063);
    wr(8'h0C, 32'h0000_0002, 4'h1);
    wr(8'h04, 32'h0000_000D, 4'h1);
    tick(1'b1, 10);
    rdChk(8'h14, 32'h0001_000A);
    wr(8'h04, 32'h0000_0005, 4'h1);
    rdChk(8'h14, 32'h0000_0000);
    wr(8'h04, 32'h0000_000D, 4'h1);
    tick(1'b0, 20);
    tick(1'b1, 511);
    rdChk(8'h14, 32'h0001_01FF);
    chk(32'(irqCount), 32'h1);
    tick(1'b1, 1);
    chk(32'(irqCount), 32'h2);
    // service: stop, select fast, drop slow
    wr(8'h04, 32'h0000_0005, 4'h1);
    sys(8'hC0, 3'b110);
    sys(8'h80, 3'b100);
    tally_and_finish();
  end
endmodule : test_cascaded_warmup_counter
